/* core/isc_map.svh */
// Purpose: named offsets, codes and counts of the interrupt/standby control
// Assumes: included by the package and by each design file that needs it
// Notes:   definitions only
`ifndef ISC_MAP_SVH
`define ISC_MAP_SVH

// request source count and vector count
`define ISC_NSRC        12
`define ISC_NVEC        9
`define ISC_NPIN        4

// source positions in the pending vector
`define ISC_SRC_PIN_A   4'h0
`define ISC_SRC_PIN_B   4'h1
`define ISC_SRC_PIN_C   4'h2
`define ISC_SRC_T0_LO   4'h3
`define ISC_SRC_PIN_D   4'h4
`define ISC_SRC_T0_HI   4'h5
`define ISC_SRC_T1_HI   4'h6
`define ISC_SRC_T1_LO   4'h7
`define ISC_SRC_SERIAL  4'h8
`define ISC_SRC_VSYNC   4'h9
`define ISC_SRC_ROW_END 4'hA
`define ISC_SRC_PORT0   4'hB

// vector numbers
`define ISC_VEC_PIN_A   4'h0
`define ISC_VEC_PIN_B   4'h1
`define ISC_VEC_PIN_C   4'h2
`define ISC_VEC_PIN_D   4'h3
`define ISC_VEC_T0_HI   4'h4
`define ISC_VEC_TIMER1  4'h5
`define ISC_VEC_SERIAL  4'h6
`define ISC_VEC_DISPLAY 4'h7
`define ISC_VEC_PORT0   4'h8

// vector entry addresses: first one fixed, the rest spaced by eight
`define ISC_VADDR_BASE  8'h03
`define ISC_VADDR_STEP  8'h08

// priority level codes
`define ISC_LVL_LOW     2'h0
`define ISC_LVL_HIGH    2'h1
`define ISC_LVL_TOP     2'h2
`define ISC_NLVL        3

`endif

/* core/isc_pkg.sv */
// Purpose: types shared by the interrupt/standby control
// Assumes: isc_map.svh gives the counts
// Notes:   types only
`include "isc_map.svh"

package isc_pkg;

    // trigger choices of an external pin
    typedef enum logic [2:0] {
        ISC_TRIG_RISE,
        ISC_TRIG_FALL,
        ISC_TRIG_BOTH,
        ISC_TRIG_HIGH,
        ISC_TRIG_LOW
    } isc_trig_t;

    // request handed to the cpu core
    typedef struct packed {
        logic       valid;  // a request is presented
        logic [3:0] vec;    // vector number
        logic [7:0] addr;   // vector entry address
        logic [1:0] level;  // priority level of the request
        logic [3:0] src;    // source that won
    } isc_req_t;

    // one-cycle event pulses from the other on-chip blocks, except port0_cond, a level
    typedef struct packed {
        logic timer0_low_byte;
        logic timer0_high_byte;
        logic timer1_high_half;
        logic timer1_low_half;
        logic sync_serial_port;
        logic vertical_sync_in;
        logic row_end;
        logic port0_cond;   // level: port-0 interrupt condition present
    } isc_periph_t;

endpackage : isc_pkg

/* core/isc_pin_detect.sv */
// Purpose: synchroniser and edge/level detector for one external pin
// Assumes: pin is asynchronous to clk
// Notes:   disallowed trigger choices raise nothing
`include "isc_map.svh"

module isc_pin_detect
    import isc_pkg::*;
#(
    parameter bit ALLOW_BOTH  = 1'b1,
    parameter bit ALLOW_LEVEL = 1'b1
) (
    input  wire logic      clk,
    input  wire logic      rst_n,
    input  wire logic      ce,
    input  wire logic      pin,
    input  wire isc_trig_t mode,
    output logic           hit,      // request this cycle
    output logic           lvl_match // selected level present now
);

    logic s1_q, s2_q, prev_q;     // sync stages and last sampled level
    logic s1_d, s2_d, prev_d;

    // next values: each stage advances only while ce is high; the decode looks at s2 and prev, never s1
    always_comb begin
        s1_d   = ce ? pin  : s1_q;
        s2_d   = ce ? s1_q : s2_q;
        prev_d = ce ? s2_q : prev_q;
    end

    always_ff @(posedge clk) begin
        // preload with the pin: a pin resting at its active level
        // would otherwise look like an edge right after release
        if (!rst_n) begin
            s1_q   <= pin;
            s2_q   <= pin;
            prev_q <= pin;
        end else begin
            s1_q   <= s1_d;
            s2_q   <= s2_d;
            prev_q <= prev_d;
        end
    end

    // trigger decode against the allowed set
    always_comb begin
        hit       = 1'b0;
        lvl_match = 1'b0;
        case (mode)
            ISC_TRIG_RISE: hit = s2_q & ~prev_q;
            ISC_TRIG_FALL: hit = ~s2_q & prev_q;
            ISC_TRIG_BOTH: hit = ALLOW_BOTH & (s2_q ^ prev_q);
            ISC_TRIG_HIGH: begin
                hit       = ALLOW_LEVEL & s2_q;
                lvl_match = ALLOW_LEVEL & s2_q;
            end
            ISC_TRIG_LOW: begin
                hit       = ALLOW_LEVEL & ~s2_q;
                lvl_match = ALLOW_LEVEL & ~s2_q;
            end
            default: hit = 1'b0;
        endcase
    end

endmodule : isc_pin_detect

/* core/isc_ctrl.sv */
// Purpose: interrupt priority, vectoring and standby control of the mcu
// Assumes: cpu pulses ack for the presented request and ret at service end
// Notes:   all state freezes while ce is low
//          events that arrive while frozen are lost, not queued
//          a shared vector is retired one source at a time
//          pins are taken as asynchronous and pass two stages
//
// Overview of operation
// - three levels, higher level nests over lower
// - other sources choose low or high
// - pins a and b choose high or highest
// - twelve sources folded onto nine vectors
// - shared vectors for pin c/timer0, timer1, display
// - pin a edges or levels, vector 03h
// - pin b same choices as pin a
// - halt stops execution, any enabled request releases
// - deep standby stops both system oscillators
// - deep standby left by reset, pin level, port0
`include "isc_map.svh"

module isc_ctrl
    import isc_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    // pin and event inputs
    input  wire logic [`ISC_NPIN-1:0]     ext_irq_pin,
    input  wire isc_trig_t [`ISC_NPIN-1:0] pin_trig,
    input  wire isc_periph_t              periph,
    // software controls
    input  wire logic [`ISC_NSRC-1:0]     src_enable,
    input  wire logic [`ISC_NSRC-1:0]     prio_up,
    input  wire logic [`ISC_NSRC-1:0]     sw_clear,
    // cpu handshake
    input  wire logic                     cpu_ack,
    input  wire logic                     cpu_ret,
    // standby commands
    input  wire logic                     halt_cmd,
    input  wire logic                     hold_cmd,
    // outputs, all registered
    output isc_req_t                      irq_q,
    output logic [`ISC_NSRC-1:0]          pending_q,
    output logic [`ISC_NLVL-1:0]          in_service_q,
    output logic                          halted_q,
    output logic                          held_q,
    output logic                          rc_osc_stop_q,
    output logic                          cf_osc_stop_q
);

    // internal nets; every output port above is a flip-flop
    logic [`ISC_NPIN-1:0] pin_hit;   // per-pin request pulse or level
    logic [`ISC_NPIN-1:0] pin_lvl;   // per-pin selected level present
    logic [`ISC_NSRC-1:0] src_set;   // set terms for the pending flags
    logic [`ISC_NSRC-1:0] pend_d;    // next pending flags
    logic [`ISC_NLVL-1:0] isr_d;     // next in-service levels
    isc_req_t             irq_d;     // next presented request
    logic                 halt_d;    // next halt state
    logic                 hold_d;    // next hold state

    // pins a, b: no dual edge
    // pins c, d: edges only
    // one detector per pin: a, b take levels, c, d take both edges
    genvar gi;
    generate
        // parameters bar the refused trigger choices per pin
        for (gi = 0; gi < `ISC_NPIN; gi++) begin : g_pin
            isc_pin_detect #(
                .ALLOW_BOTH  (gi >= 2),
                .ALLOW_LEVEL (gi < 2)
            ) u_det (
                .clk       (clk),
                .rst_n     (rst_n),
                .ce        (ce),
                .pin       (ext_irq_pin[gi]),
                .mode      (pin_trig[gi]),
                .hit       (pin_hit[gi]),
                .lvl_match (pin_lvl[gi])
            );
        end
    endgenerate

    // source level from the per-source choice
    function automatic logic [1:0] src_level(input int unsigned s, input logic up);
        // pins a, b: high or highest
        if (s == `ISC_SRC_PIN_A || s == `ISC_SRC_PIN_B) begin
            return up ? `ISC_LVL_TOP : `ISC_LVL_HIGH;
        end
        // others: low or high
        // the top level stays reserved for pins a and b
        return up ? `ISC_LVL_HIGH : `ISC_LVL_LOW;
    endfunction : src_level

    function automatic logic [3:0] src_vector(input int unsigned s);
        case (s)
            `ISC_SRC_PIN_A:   return `ISC_VEC_PIN_A;
            `ISC_SRC_PIN_B:   return `ISC_VEC_PIN_B;
            // pin c with timer0 low byte
            `ISC_SRC_PIN_C:   return `ISC_VEC_PIN_C;
            `ISC_SRC_T0_LO:   return `ISC_VEC_PIN_C;
            `ISC_SRC_PIN_D:   return `ISC_VEC_PIN_D;
            `ISC_SRC_T0_HI:   return `ISC_VEC_T0_HI;
            `ISC_SRC_T1_HI:   return `ISC_VEC_TIMER1;
            `ISC_SRC_T1_LO:   return `ISC_VEC_TIMER1;
            `ISC_SRC_SERIAL:  return `ISC_VEC_SERIAL;
            `ISC_SRC_VSYNC:   return `ISC_VEC_DISPLAY;
            `ISC_SRC_ROW_END: return `ISC_VEC_DISPLAY;
            // port0 and any unused code
            default:          return `ISC_VEC_PORT0;
        endcase
    endfunction : src_vector

    // vector entry address, first is 03h
    function automatic logic [7:0] vec_addr(input logic [3:0] v);
        logic [7:0] ofs;
        // entries sit one step apart after the fixed first one
        ofs = 8'(v) * `ISC_VADDR_STEP;
        return `ISC_VADDR_BASE + ofs;
    endfunction : vec_addr

    // gather set terms; port0 raises only on its rising condition
    logic port0_prev_q;
    logic port0_prev_d;
    always_comb begin
        src_set                   = '0;
        // pin detector outputs
        src_set[`ISC_SRC_PIN_A]   = pin_hit[0];
        src_set[`ISC_SRC_PIN_B]   = pin_hit[1];
        src_set[`ISC_SRC_PIN_C]   = pin_hit[2];
        src_set[`ISC_SRC_PIN_D]   = pin_hit[3];
        // peripheral pulses pass straight to the set terms
        src_set[`ISC_SRC_T0_LO]   = periph.timer0_low_byte;
        src_set[`ISC_SRC_T0_HI]   = periph.timer0_high_byte;
        src_set[`ISC_SRC_T1_HI]   = periph.timer1_high_half;
        src_set[`ISC_SRC_T1_LO]   = periph.timer1_low_half;
        src_set[`ISC_SRC_SERIAL]  = periph.sync_serial_port;
        src_set[`ISC_SRC_VSYNC]   = periph.vertical_sync_in;
        src_set[`ISC_SRC_ROW_END] = periph.row_end;
        src_set[`ISC_SRC_PORT0]   = periph.port0_cond & ~port0_prev_q;
    end

    // port0 edge memory: a held condition raises one request only
    always_comb begin
        port0_prev_d = port0_prev_q;
        // frozen with the rest while ce is low
        if (ce) begin
            port0_prev_d = periph.port0_cond;
        end
    end

    // pending flags: held until serviced or cleared
    // set wins: an event in the clearing cycle is kept
    always_comb begin
        pend_d = pending_q;
        if (ce) begin
            // software clear first
            pend_d = pending_q & ~sw_clear;
            // ack retires only the winner of a shared vector
            if (cpu_ack && irq_q.valid) begin
                pend_d[irq_q.src] = 1'b0;
            end
            // new events last, so they survive both clears
            pend_d = pend_d | src_set;
        end
    end

    // service levels: return ends the innermost level
    always_comb begin
        isr_d = in_service_q;
        if (ce) begin
            if (cpu_ret) begin
                if (in_service_q[`ISC_LVL_TOP]) begin
                    isr_d[`ISC_LVL_TOP] = 1'b0;
                end else if (in_service_q[`ISC_LVL_HIGH]) begin
                    isr_d[`ISC_LVL_HIGH] = 1'b0;
                end else begin
                    isr_d[`ISC_LVL_LOW] = 1'b0;
                end
            end
            // ack applied last: a level opened now survives a return
            if (cpu_ack && irq_q.valid) begin
                isr_d[irq_q.level] = 1'b1;
            end
        end
    end

    // pick highest level above all in service
    // lower source number wins within a level
    always_comb begin
        logic [1:0]  best_lvl;
        logic        found;
        logic [1:0]  lv;
        best_lvl = `ISC_LVL_LOW;
        found    = 1'b0;
        lv       = `ISC_LVL_LOW;
        // ce low: the presented request is frozen too
        irq_d    = irq_q;
        if (ce) begin
            // rebuilt every cycle; a cleared source drops out at once
            irq_d = '0;
            // ascending scan: lower source wins a tie in level
            for (int s = 0; s < `ISC_NSRC; s++) begin
                // equal level to one in service waits: no self-nesting
                lv = src_level(s, prio_up[s]);
                if (pend_d[s] && src_enable[s] && ((isr_d >> lv) == '0)
                    && (!found || lv > best_lvl)) begin
                    found       = 1'b1;
                    best_lvl    = lv;
                    irq_d.valid = 1'b1;
                    irq_d.level = lv;
                    irq_d.src   = 4'(s);
                    irq_d.vec   = src_vector(s);
                    irq_d.addr  = vec_addr(src_vector(s));
                end
            end
        end
    end

    // standby states
    always_comb begin
        halt_d = halted_q;
        hold_d = held_q;
        if (ce) begin
            // wake terms win over entry commands in the same cycle
            // any enabled request ends halt
            // halt_cmd with a request already waiting is ignored
            if (|(pend_d & src_enable)) begin
                halt_d = 1'b0;
            end else if (halt_cmd) begin
                halt_d = 1'b1;
            end
            // pin a/b level or port0 ends hold
            // limitation: pins a, b wake only from a level mode
            if (pin_lvl[0] || pin_lvl[1] || periph.port0_cond) begin
                hold_d = 1'b0;
            end else if (hold_cmd) begin
                hold_d = 1'b1;
            end
        end
    end

    // pending register
    // flags survive ce low and clear only on reset here
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pending_q <= '0;
        end else begin
            pending_q <= pend_d;
        end
    end

    // in-service register
    // one bit per level, so nesting depth is at most three
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_service_q <= '0;
        end else begin
            in_service_q <= isr_d;
        end
    end

    // presented request register
    // cpu sees a settled request one edge after its event
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_q <= '0;
        end else begin
            irq_q <= irq_d;
        end
    end

    // port0 edge memory register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port0_prev_q <= 1'b0;
        end else begin
            port0_prev_q <= port0_prev_d;
        end
    end

    // standby registers; reset is the remaining release path
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            halted_q      <= 1'b0;
            held_q        <= 1'b0;
            rc_osc_stop_q <= 1'b0;
            cf_osc_stop_q <= 1'b0;
        end else begin
            // halt and hold follow their next values
            halted_q      <= halt_d;
            held_q        <= hold_d;
            // both oscillators stop in hold
            // limitation: no restart settling wait is modelled here
            rc_osc_stop_q <= hold_d;
            cf_osc_stop_q <= hold_d;
        end
    end

endmodule : isc_ctrl

/* verif/isc_ctrl_chk.sv */
// Purpose: port assertions of the interrupt/standby control
// Assumes: one clock domain, bound to isc_ctrl
// Notes:   ack check skips pins a, b (level modes re-set them)
`include "isc_map.svh"
module isc_ctrl_chk
    import isc_pkg::*;
(
    input wire logic            clk,
    input wire logic            rst_n,
    input wire logic            ce,
    input wire logic [3:0]      ext_irq_pin,
    input wire isc_trig_t [3:0] pin_trig,
    input wire isc_periph_t     periph,
    input wire logic [11:0]     src_enable,
    input wire logic            cpu_ack,
    input wire isc_req_t        irq_q,
    input wire logic [11:0]     pending_q,
    input wire logic [2:0]      in_service_q,
    input wire logic            halted_q,
    input wire logic            held_q,
    input wire logic            rc_osc_stop_q,
    input wire logic            cf_osc_stop_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // vector that each source folds onto
    function automatic logic [3:0] vmap(input logic [3:0] s);
        case (s)
            4'h0, 4'h1, 4'h2: vmap = s;
            4'h3: vmap = 4'h2;
            4'h4: vmap = 4'h3;
            4'h5: vmap = 4'h4;
            4'h6, 4'h7: vmap = 4'h5;
            4'h8: vmap = 4'h6;
            4'h9, 4'hA: vmap = 4'h7;
            default: vmap = 4'h8;
        endcase
    endfunction : vmap
    AST_VEC: assert property (irq_q.valid |-> irq_q.vec == vmap(irq_q.src)
        && irq_q.addr == 8'h03 + {irq_q.vec, 3'b000}) else $error("vector wrong");
    AST_LVL_AB: assert property (irq_q.valid && irq_q.src < 4'h2
        |-> irq_q.level inside {2'h1, 2'h2}) else $error("pin level wrong");
    AST_LVL_OTH: assert property (irq_q.valid && irq_q.src > 4'h1
        |-> irq_q.level inside {2'h0, 2'h1}) else $error("source level wrong");
    AST_NEST: assert property (irq_q.valid
        |-> (in_service_q >> irq_q.level) == 3'h0) else $error("not above service");
    AST_ACK: assert property (ce && cpu_ack && irq_q.valid && irq_q.src > 4'h1
        |=> !pending_q[$past(irq_q.src)] && in_service_q[$past(irq_q.level)])
        else $error("ack not taken");
    AST_HALT: assert property (!(halted_q
        && |(pending_q & $past(src_enable)))) else $error("halt kept");
    AST_HOLD: assert property (ce && held_q && periph.port0_cond
        |=> !held_q) else $error("hold kept");
    AST_OSC: assert property (rc_osc_stop_q == held_q
        && cf_osc_stop_q == held_q) else $error("osc stop wrong");
    AST_PIN: assert property (ce && $rose(ext_irq_pin[2]) && pin_trig[2] == ISC_TRIG_RISE
        |-> ##3 pending_q[2]) else $error("pin c late");
endmodule : isc_ctrl_chk

bind isc_ctrl isc_ctrl_chk u_chk (.clk, .rst_n, .ce, .ext_irq_pin, .pin_trig, .periph,
    .src_enable, .cpu_ack, .irq_q, .pending_q, .in_service_q, .halted_q, .held_q,
    .rc_osc_stop_q, .cf_osc_stop_q);

/* verif/isc_cpu_model.sv */
// Purpose: cpu core stand-in taking and retiring requests
// Assumes: acks only a presented request
// Notes:   each routine lasts SVC cycles, innermost retired first
module isc_cpu_model
    import isc_pkg::*;
#(
    parameter int SVC = 30
) (
    input  wire logic     clk,
    input  wire logic     rst_n,
    input  wire isc_req_t irq_q,
    input  wire logic     ack_en,
    output logic          cpu_ack,
    output logic          cpu_ret
);
    timeunit 1ns;
    timeprecision 1ps;
    int depth; // open routines
    int svc;   // cycles in innermost routine
    initial {cpu_ack, cpu_ret} = 2'b00;
    always @(posedge clk) begin
        cpu_ack <= 1'b0;
        cpu_ret <= 1'b0;
        svc <= svc + 1;
        if (!rst_n) begin
            depth <= 0;
            svc <= 0;
        end else if (ack_en && irq_q.valid && !cpu_ack) begin
            cpu_ack <= 1'b1;
            depth <= depth + 1;
            svc <= 0;
        end else if (depth > 0 && svc >= SVC) begin
            cpu_ret <= 1'b1;
            depth <= depth - 1;
            svc <= 0;
        end
    end
endmodule : isc_cpu_model

/* verif/isc_ctrl_tb.sv */
// Purpose: self-checking bench of the interrupt/standby control
// Assumes: cpu stand-in acks every presented request while ack_en is high
// Notes:   pin trigger modes swept by loop, ce low in one step only
module isc_ctrl_tb
    import isc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] PSRC [8] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB};
    localparam logic [3:0] PVEC [8] = '{4'h2, 4'h4, 4'h5, 4'h5, 4'h6, 4'h7, 4'h7, 4'h8};
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, ack_en = 1'b1;
    logic halt_cmd = 1'b0, hold_cmd = 1'b0, cpu_ack, cpu_ret;
    logic [3:0]       ext_irq_pin = 4'h0;
    isc_trig_t [3:0]  pin_trig = '{default: ISC_TRIG_RISE};
    isc_periph_t      periph = '0;
    logic [11:0]      src_enable = 12'hFFF, prio_up = 12'h000, sw_clear = 12'h000;
    isc_req_t         irq_q;
    logic [11:0]      pending_q;
    logic [2:0]       in_service_q;
    logic             halted_q, held_q, rc_osc_stop_q, cf_osc_stop_q;
    int               n_errors = 0, n_checks = 0;
    isc_ctrl uut (.clk, .rst_n, .ce, .ext_irq_pin, .pin_trig, .periph, .src_enable, .prio_up,
        .sw_clear, .cpu_ack, .cpu_ret, .halt_cmd, .hold_cmd, .irq_q, .pending_q,
        .in_service_q, .halted_q, .held_q, .rc_osc_stop_q, .cf_osc_stop_q);
    isc_cpu_model #(.SVC(30)) cpu (.clk, .rst_n, .irq_q, .ack_en, .cpu_ack, .cpu_ret);
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, n_checks);
        if (n_errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // bounded wait for a presented request
    task automatic wait_req(input int k, output logic seen);
        seen = 1'b0;
        repeat (k) begin
            @(posedge clk);
            #1;
            if (irq_q.valid === 1'b1 && !seen) seen = 1'b1;
            if (seen) break;
        end
    endtask : wait_req
    // clear stale requests, then wait for all routines to retire
    task automatic settle();
        int i;
        tick(6);
        sw_clear <= 12'hFFF;
        @(posedge clk);
        sw_clear <= 12'h000;
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            #1;
            if (in_service_q === 3'h0 && !irq_q.valid && pending_q === 12'h000) break;
        end
        if (i == 400) begin
            n_errors++;
            $display("wrong value at %0t: never idle", $time);
            final_report();
        end
    endtask : settle
    initial begin
        logic seen;
        logic idle;
        logic fire;
        tick(20);
        rst_n <= 1'b1;
        #1;
        chk({irq_q, pending_q, in_service_q, halted_q, held_q}, 40'h0);
        // each on-chip source and the vector it folds onto
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            periph <= isc_periph_t'(8'h80 >> i);
            @(posedge clk);
            periph <= '0;
            wait_req(6, seen);
            chk({seen, irq_q.src, irq_q.vec, irq_q.level}, {1'b1, PSRC[i], PVEC[i], 2'h0});
            settle();
        end
        // every pin in every trigger mode, refused ones included
        for (int p = 0; p < 4; p++) begin
            for (int m = 0; m < 5; m++) begin
                idle = (m == 1 || m == 4);
                fire = (p < 2) ? (m != 2) : (m < 3);
                @(posedge clk);
                pin_trig[p] <= isc_trig_t'(m);
                ext_irq_pin[p] <= idle;
                settle();
                @(posedge clk);
                ext_irq_pin[p] <= ~idle;
                wait_req(8, seen);
                chk(seen, fire);
                if (fire)
                    chk({irq_q.vec, irq_q.level, irq_q.addr}, {p[3:0], (p < 2) ? 2'h1 : 2'h0, 8'h03 + 8'(p * 8)});
                @(posedge clk);
                ext_irq_pin[p] <= idle;
                settle();
            end
        end
        // nesting: highest pin over a high routine, low held back
        @(posedge clk);
        prio_up <= 12'h101;
        pin_trig[0] <= ISC_TRIG_RISE;
        ext_irq_pin[0] <= 1'b0;
        ack_en <= 1'b0;
        settle();
        @(posedge clk);
        periph <= 8'h28;
        @(posedge clk);
        periph <= '0;
        wait_req(4, seen);
        chk({seen, irq_q.src, irq_q.level}, {1'b1, 4'h8, 2'h1});
        @(posedge clk);
        ack_en <= 1'b1;
        tick(3);
        #1;
        chk({irq_q.valid, in_service_q}, {1'b0, 3'h2});
        @(posedge clk);
        ext_irq_pin[0] <= 1'b1;
        wait_req(6, seen);
        chk({seen, irq_q.src, irq_q.level}, {1'b1, 4'h0, 2'h2});
        tick(2);
        #1;
        chk(in_service_q, 3'h6);
        @(posedge clk);
        ext_irq_pin[0] <= 1'b0;
        prio_up <= 12'h000;
        settle();
        // halt: disabled source must not release, enabled one must
        @(posedge clk);
        src_enable <= 12'hDFF;
        halt_cmd <= 1'b1;
        @(posedge clk);
        halt_cmd <= 1'b0;
        periph <= 8'h04;
        @(posedge clk);
        periph <= '0;
        tick(4);
        #1;
        chk({halted_q, pending_q[9]}, 2'b11);
        @(posedge clk);
        periph <= 8'h02;
        @(posedge clk);
        periph <= '0;
        #1;
        chk(halted_q, 1'b0);
        @(posedge clk);
        src_enable <= 12'hFFF;
        settle();
        // clock enable low: an event in a frozen cycle is not taken
        @(posedge clk);
        ce <= 1'b0;
        periph <= 8'h40;
        @(posedge clk);
        periph <= '0;
        tick(2);
        #1;
        chk({irq_q.valid, pending_q}, 13'h0000);
        @(posedge clk);
        ce <= 1'b1;
        // deep standby left by pin b low level, port 0, reset
        for (int w = 0; w < 3; w++) begin
            @(posedge clk);
            hold_cmd <= 1'b1;
            @(posedge clk);
            hold_cmd <= 1'b0;
            #1;
            chk({held_q, rc_osc_stop_q, cf_osc_stop_q}, 3'h7);
            @(posedge clk);
            if (w == 0)
                ext_irq_pin[1] <= 1'b0;
            else if (w == 1)
                periph <= 8'h01;
            else
                rst_n <= 1'b0;
            tick(4);
            #1;
            chk({held_q, rc_osc_stop_q, cf_osc_stop_q}, 3'h0);
            @(posedge clk);
            ext_irq_pin[1] <= 1'b1;
            periph <= '0;
            rst_n <= 1'b1;
            // pin b resting high in low-level mode must not fake a request after reset
            if (w == 2) begin
                tick(2);
                #1;
                chk(pending_q, 12'h000);
            end
            settle();
        end
        final_report();
    end
endmodule : isc_ctrl_tb
